// ==== logic/rms_defs.svh ====
// Constants of the rotate-and-mask unit
// Summary of operation
// - Extract n-bit field, justify, zero others
// - Insert justified field at b, keep rest
// - Rotate whole word by n or by register amount, no mask
// - Logical shift by n, zero fill
// - Clear leftmost or rightmost n bits
// - Clear leftmost b bits, then shift left
// - Record variant when record bit set, word ops only (never for double extract)
// - Right extract is rotate b+n, mask 32-n..31
// - Right rotate is left rotate 32-n
// - Left shift is rotate n, mask 0..31-n
// - Right shift is rotate 32-n, mask n..31
// - Right insert rotates 32-(b+n), mask b..b+n-1
// - Clear-shift is rotate n, mask b-n..31-n
// - Double right extract rotates b+n, clears left; double left extract rotates b, clears right
// - Bit 0 is the most significant bit
`ifndef RMS_DEFS_SVH
`define RMS_DEFS_SVH
`define RMS_WORD_BITS 32
`define RMS_DWORD_BITS 64
`define RMS_ZERO_WORD 32'h0000_0000
`define RMS_ONES_WORD 32'hFFFF_FFFF
`define RMS_ZERO_DWORD 64'h0000_0000_0000_0000
`endif

// ==== logic/rms_pkg.sv ====
// Types of the rotate-and-mask unit
package rms_pkg;
	typedef enum logic [3:0] {
		OP_EXT_LEFT,
		OP_EXT_RIGHT,
		OP_INS_LEFT,
		OP_INS_RIGHT,
		OP_ROT_LEFT,
		OP_ROT_RIGHT,
		OP_SHIFT_LEFT,
		OP_SHIFT_RIGHT,
		OP_CLR_LEFT,
		OP_CLR_RIGHT,
		OP_CLR_SHIFT,
		OP_DEXT_LEFT,
		OP_DEXT_RIGHT,
		OP_ROT_REG
	} op_t;

	typedef struct packed {
		logic        valid;
		op_t         op;
		logic        record_flag_bit;
		logic [63:0] source_operand;
		logic [31:0] destination_operand;
		logic [5:0]  shift_amount_operand;
		logic [6:0]  n;
		logic [5:0]  b;
	} req_t;

	typedef struct packed {
		logic        valid;
		logic [63:0] result;
		logic        record;
		logic [2:0]  cond;
	} rsp_t;

	typedef struct packed {
		rsp_t rsp;
	} state_t;
endpackage

// ==== logic/rms_rotmask.sv ====
// Word or double-word rotate-and-mask primitive with optional insert
`timescale 1ns/1ps
`include "rms_defs.svh"
module rms_rotmask #(
	parameter int WIDTH = `RMS_WORD_BITS
) (
	input  wire logic [WIDTH-1:0] src,
	input  wire logic [WIDTH-1:0] dst,
	input  wire logic [5:0]       rot,
	input  wire logic [5:0]       mb,
	input  wire logic [5:0]       me,
	input  wire logic             insert,
	output logic      [WIDTH-1:0] res
);
	// Only the word and double-word rotators are served
	if (WIDTH != 32 && WIDTH != 64)
	begin : g_bad_width
		$error("rms_rotmask: WIDTH must be 32 or 64");
	end

	logic [WIDTH-1:0] rotated;
	logic [WIDTH-1:0] mask;
	logic [2*WIDTH-1:0] dbl;
	int unsigned r;
	int unsigned k;

	always_comb
	begin
		r = 32'(rot) % WIDTH;
		dbl = {src, src} << r;
		rotated = dbl[2*WIDTH-1:WIDTH];
		// Index k counts from the most significant end
		for (int i = 0; i < WIDTH; i++)
		begin
			k = 32'(WIDTH - 1 - i);
			if (mb <= me)
				mask[i] = (k >= 32'(mb)) && (k <= 32'(me));
			else
				mask[i] = (k >= 32'(mb)) || (k <= 32'(me));
		end
		if (insert)
			res = (rotated & mask) | (dst & ~mask);
		else
			res = rotated & mask;
	end
endmodule // rms_rotmask

// ==== logic/rms_unit.sv ====
// Rotate, shift, clear, extract and insert execution unit
`timescale 1ns/1ps
`include "rms_defs.svh"
module rms_unit (
	input  wire logic          clock,
	input  wire logic          rst,
	input  wire rms_pkg::req_t req,
	output rms_pkg::rsp_t      rsp
);
	rms_pkg::state_t  state_r;
	rms_pkg::state_t  state_nxt;
	logic [5:0]       rot;
	logic [5:0]       mb;
	logic [5:0]       me;
	logic             ins;
	logic             dword;
	logic [31:0]      wres;
	logic [63:0]      dres;
	logic [6:0]       n;
	logic [6:0]       b;

	assign n = req.n;
	assign b = {1'b0, req.b};

	// Each operation becomes a rotate amount and a mask span
	always_comb
	begin
		rot = 6'h00;
		mb = 6'h00;
		me = 6'h1F;
		ins = 1'b0;
		dword = 1'b0;
		case (req.op)
			rms_pkg::OP_EXT_LEFT:
			begin
				rot = b[5:0];
				me = 6'(n - 7'h01);
			end
			rms_pkg::OP_EXT_RIGHT:
			begin
				rot = 6'(b + n);
				mb = 6'(7'h20 - n);
			end
			rms_pkg::OP_INS_LEFT:
			begin
				rot = 6'(7'h20 - b);
				mb = b[5:0];
				me = 6'(b + n - 7'h01);
				ins = 1'b1;
			end
			rms_pkg::OP_INS_RIGHT:
			begin
				rot = 6'(7'h20 - (b + n));
				mb = b[5:0];
				me = 6'(b + n - 7'h01);
				ins = 1'b1;
			end
			rms_pkg::OP_ROT_LEFT:
				rot = n[5:0];
			rms_pkg::OP_ROT_RIGHT:
				rot = 6'(7'h20 - n);
			rms_pkg::OP_ROT_REG:
				rot = {1'b0, req.shift_amount_operand[4:0]};
			rms_pkg::OP_SHIFT_LEFT:
			begin
				rot = n[5:0];
				me = 6'(7'h1F - n);
			end
			rms_pkg::OP_SHIFT_RIGHT:
			begin
				rot = 6'(7'h20 - n);
				mb = n[5:0];
			end
			rms_pkg::OP_CLR_LEFT:
				mb = n[5:0];
			rms_pkg::OP_CLR_RIGHT:
				me = 6'(7'h1F - n);
			rms_pkg::OP_CLR_SHIFT:
			begin
				rot = n[5:0];
				mb = 6'(b - n);
				me = 6'(7'h1F - n);
			end
			rms_pkg::OP_DEXT_LEFT:
			begin
				rot = b[5:0];
				me = 6'(n - 7'h01);
				dword = 1'b1;
			end
			rms_pkg::OP_DEXT_RIGHT:
			begin
				rot = 6'(b + n);
				mb = 6'(7'h40 - n);
				me = 6'h3F;
				dword = 1'b1;
			end
			default:
				rot = 6'h00;
		endcase
	end

	rms_rotmask #(.WIDTH(`RMS_WORD_BITS)) u_word (
		.src    (req.source_operand[31:0]),
		.dst    (req.destination_operand),
		.rot    (rot),
		.mb     (mb),
		.me     (me),
		.insert (ins),
		.res    (wres)
	);

	rms_rotmask #(.WIDTH(`RMS_DWORD_BITS)) u_dword (
		.src    (req.source_operand),
		.dst    (`RMS_ZERO_DWORD),
		.rot    (rot),
		.mb     (mb),
		.me     (me),
		.insert (1'b0),
		.res    (dres)
	);

	always_comb
	begin
		state_nxt = state_r;
		state_nxt.rsp.valid = req.valid;
		if (req.valid)
		begin
			if (dword)
				state_nxt.rsp.result = dres;
			else
				state_nxt.rsp.result = {`RMS_ZERO_WORD, wres};
			state_nxt.rsp.record = req.record_flag_bit && !dword;
			// Condition: negative, positive, zero of the word result
			if (wres == `RMS_ZERO_WORD)
				state_nxt.rsp.cond = 3'b001;
			else if (wres[31])
				state_nxt.rsp.cond = 3'b100;
			else
				state_nxt.rsp.cond = 3'b010;
		end
		if (rst)
			state_nxt = '0;
	end

	always_ff @(posedge clock)
		state_r <= state_nxt;

	assign rsp = state_r.rsp;

	sequence s_rot_req;
		req.valid && req.op == rms_pkg::OP_ROT_LEFT;
	endsequence

	a_rotate_left: assert property (@(posedge clock) disable iff (rst)
		s_rot_req |=> rsp.result[31:0] == (($past(req.source_operand[31:0])
		<< $past(req.n[4:0])) | ($past(req.source_operand[31:0]) >>
		(7'd32 - {2'b00, $past(req.n[4:0])}))))
		else $error("rotate left result wrong");
	a_shift_left: assert property (@(posedge clock) disable iff (rst)
		req.valid && req.op == rms_pkg::OP_SHIFT_LEFT && req.n < 7'd32
		|=> rsp.result[31:0] == 32'($past(req.source_operand[31:0])
		<< $past(req.n)))
		else $error("shift left result wrong");
	a_shift_right: assert property (@(posedge clock) disable iff (rst)
		req.valid && req.op == rms_pkg::OP_SHIFT_RIGHT && req.n < 7'd32
		&& req.n > 7'd0
		|=> rsp.result[31:0] == ($past(req.source_operand[31:0])
		>> $past(req.n)))
		else $error("shift right result wrong");
	a_clear_left: assert property (@(posedge clock) disable iff (rst)
		req.valid && req.op == rms_pkg::OP_CLR_LEFT && req.n < 7'd32
		|=> rsp.result[31:0] == ($past(req.source_operand[31:0])
		& (`RMS_ONES_WORD >> $past(req.n))))
		else $error("clear left result wrong");
	a_extract_rt: assert property (@(posedge clock) disable iff (rst)
		req.valid && req.op == rms_pkg::OP_EXT_RIGHT && req.n == 7'd1
		&& req.b == 6'd0
		|=> rsp.result == {63'd0, $past(req.source_operand[31])})
		else $error("extract sign bit wrong");
	a_insert_keep: assert property (@(posedge clock) disable iff (rst)
		req.valid && req.op == rms_pkg::OP_INS_RIGHT && req.n == 7'd1
		&& req.b == 6'd0
		|=> rsp.result[30:0] == $past(req.destination_operand[30:0])
		&& rsp.result[31] == $past(req.source_operand[0]))
		else $error("insert merge wrong");
	a_clear_shift: assert property (@(posedge clock) disable iff (rst)
		req.valid && req.op == rms_pkg::OP_CLR_SHIFT && req.n <= 7'(req.b)
		&& req.b < 6'd32
		|=> rsp.result[31:0] == 32'(($past(req.source_operand[31:0])
		& (`RMS_ONES_WORD >> $past(req.b))) << $past(req.n)))
		else $error("clear and shift wrong");
	a_record_flag: assert property (@(posedge clock) disable iff (rst)
		req.valid && req.record_flag_bit && req.op == rms_pkg::OP_ROT_LEFT
		|=> rsp.record && rsp.valid)
		else $error("record flag not kept");
endmodule // rms_unit

// ==== bench/decode_model.sv ====
// Decode-stage model that presents requests to the unit
`timescale 1ns/1ps
module decode_model (
	input  wire logic     clock,
	output rms_pkg::req_t req
);
	rms_pkg::req_t nxt;
	logic          pend = 1'b0;
	initial req = '0;
	task send(input rms_pkg::req_t r);
		nxt = r;
		pend = 1'b1;
	endtask
	// Idle lines carry inverted data so stale values never pass
	always @(posedge clock)
		if (pend)
		begin
			req <= nxt;
			pend = 1'b0;
		end
		else
			req <= {1'b0, ~req[$bits(req)-2:0]};
endmodule // decode_model

// ==== bench/tb.sv ====
// Self-checking bench of the rotate-and-mask unit
`timescale 1ns/1ps
module tb;
	logic          clock;
	logic          rst;
	rms_pkg::req_t req;
	rms_pkg::rsp_t rsp;
	int            fail_count = 0;
	int            checks = 0;
	rms_unit i_dut (.clock(clock), .rst(rst), .req(req), .rsp(rsp));
	decode_model i_src (.clock(clock), .req(req));
	initial
	begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	task chk(input string s, input logic [63:0] e, input logic [63:0] g);
		checks++;
		if (g !== e)
		begin
			fail_count++;
			$display("[FAIL] %s exp %h got %h", s, e, g);
		end
	endtask
	function rms_pkg::req_t mk(input rms_pkg::op_t o, input logic [63:0] s,
		input logic [31:0] d, input logic [6:0] n, input logic [5:0] b,
		input logic r);
		mk = '{1'b1, o, r, s, d, b, n, b};
	endfunction
	task do_op(input rms_pkg::op_t o, input logic [63:0] s,
		input logic [31:0] d, input logic [6:0] n, input logic [5:0] b,
		input logic r, input logic [63:0] e);
		i_src.send(mk(o, s, d, n, b, r));
		repeat (2) @(posedge clock);
		#1;
		chk("valid", 64'h1, rsp.valid);
		chk("result", e, rsp.result);
		chk("record", r, rsp.record);
	endtask
	task t_extract;
		do_op(rms_pkg::OP_EXT_RIGHT, 64'h8000_0000, 32'h0, 7'h01, 6'h00,
			1'b1, 64'h1);
		chk("cond pos", 64'h2, rsp.cond);
		do_op(rms_pkg::OP_EXT_LEFT, 64'h1234_5678, 32'h0, 7'h08, 6'h04,
			1'b0, 64'h2300_0000);
		$display("extract done");
	endtask
	task t_insert;
		do_op(rms_pkg::OP_INS_RIGHT, 64'h1, 32'h0000_00FF, 7'h01, 6'h00,
			1'b1, 64'h8000_00FF);
		chk("cond neg", 64'h4, rsp.cond);
		do_op(rms_pkg::OP_INS_LEFT, 64'hA000_0000, 32'hFFFF_FFFF, 7'h04,
			6'h08, 1'b0, 64'hFFAF_FFFF);
		$display("insert done");
	endtask
	task t_rotshift;
		do_op(rms_pkg::OP_ROT_LEFT, 64'h1234_5678, 32'h0, 7'h04, 6'h00,
			1'b1, 64'h2345_6781);
		do_op(rms_pkg::OP_ROT_RIGHT, 64'h1234_5678, 32'h0, 7'h04, 6'h00,
			1'b1, 64'h8123_4567);
		do_op(rms_pkg::OP_ROT_REG, 64'h1234_5678, 32'h0, 7'h00, 6'h08,
			1'b0, 64'h3456_7812);
		do_op(rms_pkg::OP_SHIFT_LEFT, 64'h1234_5678, 32'h0, 7'h08, 6'h00,
			1'b0, 64'h3456_7800);
		do_op(rms_pkg::OP_SHIFT_RIGHT, 64'h1234_5678, 32'h0, 7'h08, 6'h00,
			1'b1, 64'h0012_3456);
		do_op(rms_pkg::OP_SHIFT_LEFT, 64'h3, 32'h0, 7'h1F, 6'h00,
			1'b0, 64'h8000_0000);
		$display("rotate and shift done");
	endtask
	task t_clear;
		do_op(rms_pkg::OP_CLR_LEFT, 64'h1234_5678, 32'h0, 7'h10, 6'h00,
			1'b1, 64'h5678);
		do_op(rms_pkg::OP_CLR_RIGHT, 64'h1234_5678, 32'h0, 7'h04, 6'h00,
			1'b0, 64'h1234_5670);
		do_op(rms_pkg::OP_CLR_SHIFT, 64'h1234_5678, 32'h0, 7'h02, 6'h10,
			1'b1, 64'h0001_59E0);
		$display("clear done");
	endtask
	task t_double;
		do_op(rms_pkg::OP_DEXT_RIGHT, 64'h1234_5678_9ABC_DEF0, 32'h0,
			7'h08, 6'h00, 1'b0, 64'h12);
		do_op(rms_pkg::OP_DEXT_LEFT, 64'h1234_5678_9ABC_DEF0, 32'h0,
			7'h10, 6'h08, 1'b0, 64'h3456_0000_0000_0000);
		$display("double done");
	endtask
	task t_b2b;
		i_src.send(mk(rms_pkg::OP_SHIFT_LEFT, 64'hFF, 32'h0, 7'h04, 6'h00,
			1'b1));
		@(posedge clock);
		#1;
		i_src.send(mk(rms_pkg::OP_ROT_RIGHT, 64'hFF, 32'h0, 7'h08, 6'h00,
			1'b0));
		@(posedge clock);
		#1;
		chk("first", 64'h0FF0, rsp.result);
		chk("first rec", 64'h1, rsp.record);
		@(posedge clock);
		#1;
		chk("second", 64'hFF00_0000, rsp.result);
		chk("second rec", 64'h0, rsp.record);
		$display("back to back done");
	endtask
	task results;
		$display("checks %0d failures %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		rst = 1'b1;
		repeat (16) @(posedge clock);
		#1;
		chk("reset valid", 64'h0, rsp.valid);
		@(posedge clock);
		rst <= 1'b0;
		#1;
		t_extract;
		t_insert;
		t_rotshift;
		t_clear;
		t_double;
		t_b2b;
		results;
	end
	initial
	begin
		#4000;
		fail_count++;
		results;
	end
endmodule // tb
